// [design/pwmc_clk_if.sv]
/*
  pwmc_clk_if: carries prescale settings from the register file to
  the clock generator and its clock enable pulses back.
  Assumes both ends sit on the same bus clock.
*/
interface pwmc_clk_if;
  logic run;
  logic [2:0] first_prescale_field;
  logic [2:0] second_prescale_field;
  logic [7:0] scla;
  logic [7:0] sclb;
  logic tick_a;
  logic tick_b;
  logic tick_sa;
  logic tick_sb;
  modport gen(input run, first_prescale_field, second_prescale_field, scla, sclb,
              output tick_a, tick_b, tick_sa, tick_sb);
  modport user(output run, first_prescale_field, second_prescale_field, scla, sclb,
               input tick_a, tick_b, tick_sa, tick_sb);
endinterface

// [design/pwmc_clkgen.sv]
/*
  pwmc_clkgen: prescaler for clocks A and B and scalers for SA and SB,
  all as one-cycle enable pulses on the bus clock.
  Assumes settings come from registers on the same clock.
*/
module pwmc_clkgen
  import pwmc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // settings and enables
  pwmc_clk_if.gen ck
);
  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic [SCL_CNT_W-1:0] sa_cnt;
    logic [SCL_CNT_W-1:0] sb_cnt;
  } pwmc_gen_s;

  pwmc_gen_s q;
  pwmc_gen_s next_q;
  logic [PRESC_W-1:0] mask_a;
  logic [PRESC_W-1:0] mask_b;
  logic [SCL_CNT_W-1:0] lim_a;
  logic [SCL_CNT_W-1:0] lim_b;
  logic ta;
  logic tb;

  // divide by two to the field value
  assign mask_a = PRESC_W'((8'h01 << ck.first_prescale_field) - 8'h01); // [RULE15]
  assign mask_b = PRESC_W'((8'h01 << ck.second_prescale_field) - 8'h01); // [RULE15]
  assign ta = ck.run && ((q.presc & mask_a) == mask_a);
  assign tb = ck.run && ((q.presc & mask_b) == mask_b);
  // scaled clock divides by twice the scale, zero meaning 256
  assign lim_a = (ck.scla == 8'h00) ? 9'h1FF : {ck.scla, 1'b0} - 9'h001;
  assign lim_b = (ck.sclb == 8'h00) ? 9'h1FF : {ck.sclb, 1'b0} - 9'h001;
  assign ck.tick_a = ta;
  assign ck.tick_b = tb;
  assign ck.tick_sa = ta && (q.sa_cnt == lim_a);
  assign ck.tick_sb = tb && (q.sb_cnt == lim_b);

  always_comb begin
    next_q = q;
    if (!ck.run) begin
      next_q = '0; // [RULE6]
    end else begin
      next_q.presc = q.presc + 7'h01;
      if (ta) begin
        next_q.sa_cnt = (q.sa_cnt == lim_a) ? 9'h000 : q.sa_cnt + 9'h001;
      end
      if (tb) begin
        next_q.sb_cnt = (q.sb_cnt == lim_b) ? 9'h000 : q.sb_cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_presc_stop;
    !ck.run |-> !ck.tick_a ##1 (q.presc == 7'h00);
  endproperty
  a_presc_stop: assert property (p_presc_stop) // [RULE6]
    else $error("prescaler runs with no channel enabled");

  property p_div1;
    ck.run && (ck.first_prescale_field == 3'h0) |-> ck.tick_a;
  endproperty
  a_div1: assert property (p_div1) // [RULE15]
    else $error("clock A missing at divide by one");

  sequence s_b_div2_tick;
    ck.run && (ck.second_prescale_field == 3'h1) && ck.tick_b;
  endsequence
  property p_div2;
    s_b_div2_tick ##1 (ck.run && (ck.second_prescale_field == 3'h1)) |-> !ck.tick_b
      ##1 (!ck.run || (ck.second_prescale_field != 3'h1) || ck.tick_b);
  endproperty
  a_div2: assert property (p_div2) // [RULE15]
    else $error("clock B wrong at divide by two");
endmodule // pwmc_clkgen

// [design/pwmc_pkg.sv]
/*
  pwmc_pkg: shared constants of the pwm enable, polarity and clock
  select block: register offsets, field positions, masks, widths.
  Assumes a byte-wide register port and one bus clock.
*/
package pwmc_pkg;
  localparam int NCH = 8;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int PCK_W = 3;
  localparam int PRESC_W = 7;
  localparam int SCL_CNT_W = 9;
  localparam int JOIN_LSB = 4;
  localparam int FIRST_PRESCALE_FIELD_LSB = 0;
  localparam int SECOND_PRESCALE_FIELD_LSB = 4;
  localparam logic [ADDR_W-1:0] ADDR_EN = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_POL = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_SCL = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_PRE = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_CTL = 6'h05;
  localparam logic [ADDR_W-1:0] ADDR_AB = 6'h06;
  localparam logic [ADDR_W-1:0] ADDR_SCLA = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_SCLB = 6'h09;
  localparam logic [ADDR_W-1:0] ADDR_CNT = 6'h0C;
  localparam logic [ADDR_W-1:0] ADDR_PER = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_DTY = 6'h1C;
  localparam logic [7:0] PRE_MASK = 8'h77;
  localparam logic [7:0] CTL_MASK = 8'hF0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ALL_CHAN = 8'hFF;
endpackage

// [design/pwmc_top.sv]
/*
  pwmc_top: per-channel enable, start polarity and clock select of an
  eight-channel pwm, with left aligned 8/16-bit period counting.
  Assumes a byte register port with read data one cycle after strobe.
*/
// Functional notes
// RULE1 - each channel has its own enable bit
// RULE2 - waveform waits for next source clock tick
// RULE3 - first period after enable may be irregular
// RULE4 - joined pair enabled by low channel only
// RULE5 - joined high channel enable ignored, output off
// RULE6 - prescaler stops when no channel enabled
// RULE7 - missing channel bits ignore writes, read zero
// RULE8 - polarity one: high first, low at duty
// RULE9 - polarity zero: low first, high at duty
// RULE10 - polarity writable anytime, unsynchronised
// RULE11 - clock select writable anytime
// RULE12 - scaled select picks scaled or plain clock
// RULE13 - channels 0,1,4,5: A, SA, B, SB
// RULE14 - channels 2,3,6,7: B, SB, A, SA
// RULE15 - clocks A, B divide by power of two
// RULE16 - joined pair settings come from low channel
// RULE17 - disabled channel static low, counter held
module pwmc_top
  import pwmc_pkg::*;
#(
  parameter logic [7:0] CHAN_MASK = ALL_CHAN
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // register port
  input wire logic [pwmc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [pwmc_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [pwmc_pkg::DATA_W-1:0] RDATA_O,
  // pwm pins
  output logic [pwmc_pkg::NCH-1:0] PWM_O
);
  import pwmc_pkg::*;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] pol;
    logic [7:0] scl;
    logic [7:0] pre;
    logic [7:0] ctl;
    logic [7:0] ab;
    logic [7:0] scla;
    logic [7:0] sclb;
    logic [NCH-1:0][7:0] per;
    logic [NCH-1:0][7:0] dty;
    logic [NCH-1:0][7:0] cnt;
    logic [NCH-1:0] run;
    logic [NCH-1:0] out;
    logic [7:0] rdata;
  } pwmc_state_s;

  pwmc_state_s q;
  pwmc_state_s next_q;
  logic [NCH-1:0] src_tick;
  logic [NCH-1:0] en_eff;
  logic [7:0] join_mask;
  logic [2:0] idx;
  logic [7:0] rd;

  pwmc_clk_if ck();

  pwmc_clkgen u_gen (
    .clk_i(REF_CLK_I),
    .rst_n_i(RSTN_I),
    .ck(ck.gen)
  );

  assign ck.run = |(q.en & CHAN_MASK); // [RULE6]
  assign ck.first_prescale_field = q.pre[FIRST_PRESCALE_FIELD_LSB +: PCK_W];
  assign ck.second_prescale_field = q.pre[SECOND_PRESCALE_FIELD_LSB +: PCK_W];
  assign ck.scla = q.scla;
  assign ck.sclb = q.sclb;
  assign RDATA_O = q.rdata;
  assign PWM_O = q.out;
  assign idx = ADDR_I[2:0] - ADDR_PER[2:0];

  // source clock and effective enable per channel
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam bit GRP_A = (i % 4) < 2;
    logic use_a;
    assign use_a = GRP_A ? !q.ab[i] : q.ab[i]; // [RULE13] [RULE14]
    assign src_tick[i] = use_a ? (q.scl[i] ? ck.tick_sa : ck.tick_a)
                               : (q.scl[i] ? ck.tick_sb : ck.tick_b); // [RULE12]
    if (i % 2 == 0) begin : g_hi
      assign en_eff[i] = q.en[i] && !q.ctl[JOIN_LSB + i / 2]; // [RULE5]
      assign join_mask[JOIN_LSB + i / 2] = CHAN_MASK[i] && CHAN_MASK[i+1];
    end else begin : g_lo
      assign en_eff[i] = q.en[i]; // [RULE4]
    end
  end
  assign join_mask[JOIN_LSB-1:0] = 4'h0;

  // read mux
  always_comb begin
    rd = 8'h00;
    if (ADDR_I == ADDR_EN) begin
      rd = q.en;
    end else if (ADDR_I == ADDR_POL) begin
      rd = q.pol;
    end else if (ADDR_I == ADDR_SCL) begin
      rd = q.scl;
    end else if (ADDR_I == ADDR_PRE) begin
      rd = q.pre;
    end else if (ADDR_I == ADDR_CTL) begin
      rd = q.ctl;
    end else if (ADDR_I == ADDR_AB) begin
      rd = q.ab;
    end else if (ADDR_I == ADDR_SCLA) begin
      rd = q.scla;
    end else if (ADDR_I == ADDR_SCLB) begin
      rd = q.sclb;
    end else if (ADDR_I >= ADDR_CNT && ADDR_I < ADDR_PER) begin
      rd = CHAN_MASK[idx] ? q.cnt[idx] : 8'h00;
    end else if (ADDR_I >= ADDR_PER && ADDR_I < ADDR_DTY) begin
      rd = CHAN_MASK[idx] ? q.per[idx] : 8'h00;
    end else if (ADDR_I >= ADDR_DTY && ADDR_I < ADDR_DTY + 6'h08) begin
      rd = CHAN_MASK[idx] ? q.dty[idx] : 8'h00;
    end
  end

  always_comb begin
    logic j;
    logic [15:0] per16;
    logic [15:0] dty16;
    logic [15:0] cnt16;
    logic [15:0] cnt_nx;
    j = 1'b0;
    per16 = 16'h0000;
    dty16 = 16'h0000;
    cnt16 = 16'h0000;
    cnt_nx = 16'h0000;
    next_q = q;
    next_q.rdata = RD_I ? rd : 8'h00;
    // writes land at once, no sync to the waveform
    if (WR_I) begin
      if (ADDR_I == ADDR_EN) begin
        next_q.en = WDATA_I & CHAN_MASK; // [RULE1] [RULE7]
      end else if (ADDR_I == ADDR_POL) begin
        next_q.pol = WDATA_I & CHAN_MASK; // [RULE10] [RULE7]
      end else if (ADDR_I == ADDR_SCL) begin
        next_q.scl = WDATA_I & CHAN_MASK; // [RULE11] [RULE7]
      end else if (ADDR_I == ADDR_PRE) begin
        next_q.pre = WDATA_I & PRE_MASK;
      end else if (ADDR_I == ADDR_CTL) begin
        next_q.ctl = WDATA_I & CTL_MASK & join_mask; // [RULE7]
      end else if (ADDR_I == ADDR_AB) begin
        next_q.ab = WDATA_I & CHAN_MASK; // [RULE11] [RULE7]
      end else if (ADDR_I == ADDR_SCLA) begin
        next_q.scla = WDATA_I;
      end else if (ADDR_I == ADDR_SCLB) begin
        next_q.sclb = WDATA_I;
      end else if (ADDR_I >= ADDR_PER && ADDR_I < ADDR_DTY) begin
        if (CHAN_MASK[idx]) begin
          next_q.per[idx] = WDATA_I;
        end
      end else if (ADDR_I >= ADDR_DTY && ADDR_I < ADDR_DTY + 6'h08) begin
        if (CHAN_MASK[idx]) begin
          next_q.dty[idx] = WDATA_I;
        end
      end
    end
    for (int i = 0; i < NCH; i++) begin
      // joined low channel counts over both bytes
      j = (i % 2 == 1) && q.ctl[JOIN_LSB + i / 2]; // [RULE16]
      per16 = j ? {q.per[i & 6], q.per[i]} : {8'h00, q.per[i]};
      dty16 = j ? {q.dty[i & 6], q.dty[i]} : {8'h00, q.dty[i]};
      cnt16 = j ? {q.cnt[i & 6], q.cnt[i]} : {8'h00, q.cnt[i]};
      cnt_nx = cnt16;
      if (!en_eff[i]) begin
        next_q.run[i] = 1'b0;
        next_q.out[i] = 1'b0; // [RULE17] [RULE5]
      end else if (!q.run[i]) begin
        // counter resumes from held value
        next_q.run[i] = src_tick[i]; // [RULE2] [RULE3]
        next_q.out[i] = 1'b0;
      end else begin
        next_q.out[i] = (cnt16 < dty16) ? q.pol[i] : !q.pol[i]; // [RULE8] [RULE9]
        if (src_tick[i]) begin
          if (per16 == 16'h0000 || cnt16 >= per16 - 16'h0001) begin
            cnt_nx = 16'h0000;
          end else begin
            cnt_nx = cnt16 + 16'h0001;
          end
          next_q.cnt[i] = cnt_nx[7:0];
          if (j) begin
            next_q.cnt[i & 6] = cnt_nx[15:8]; // [RULE16]
          end
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  property p_en_off;
    !q.en[3] |=> !PWM_O[3];
  endproperty
  a_en_off: assert property (p_en_off) // [RULE1]
    else $error("disabled channel 3 output not low");

  sequence s_armed;
    q.en[1] && !q.run[1] && !src_tick[1];
  endsequence
  property p_wait_tick;
    s_armed |=> !q.run[1] && !PWM_O[1];
  endproperty
  a_wait_tick: assert property (p_wait_tick) // [RULE2]
    else $error("channel 1 started before its source tick");

  property p_join_hi_off;
    q.ctl[4] |=> !PWM_O[0];
  endproperty
  a_join_hi_off: assert property (p_join_hi_off) // [RULE5]
    else $error("joined high channel 0 output active");

  property p_join_lo;
    q.ctl[4] && q.en[1] && src_tick[1] ##1 q.ctl[4] && q.en[1] |-> q.run[1];
  endproperty
  a_join_lo: assert property (p_join_lo) // [RULE4]
    else $error("joined pair not started by low channel");

  property p_pol_one;
    q.en[1] && q.run[1] && !q.ctl[4] && q.pol[1] && (q.cnt[1] < q.dty[1])
      |=> PWM_O[1];
  endproperty
  a_pol_one: assert property (p_pol_one) // [RULE8]
    else $error("polarity one output not high before duty");

  property p_pol_zero;
    q.en[1] && q.run[1] && !q.ctl[4] && !q.pol[1] && (q.cnt[1] < q.dty[1])
      |=> !PWM_O[1];
  endproperty
  a_pol_zero: assert property (p_pol_zero) // [RULE9]
    else $error("polarity zero output not low before duty");

  property p_sel_a;
    !q.scl[0] && !q.ab[0] |-> src_tick[0] == ck.tick_a;
  endproperty
  a_sel_a: assert property (p_sel_a) // [RULE13]
    else $error("channel 0 not on clock A");

  property p_sel_sb;
    q.scl[2] && !q.ab[2] |-> src_tick[2] == ck.tick_sb;
  endproperty
  a_sel_sb: assert property (p_sel_sb) // [RULE14] [RULE12]
    else $error("channel 2 not on clock SB");

  property p_missing;
    ((q.en | q.pol | q.scl | q.ab) & ~CHAN_MASK) == 8'h00;
  endproperty
  a_missing: assert property (p_missing) // [RULE7]
    else $error("missing channel bit set");

  property p_rd_en;
    RD_I && (ADDR_I == ADDR_EN) |=> RDATA_O == $past(q.en);
  endproperty
  a_rd_en: assert property (p_rd_en) // [RULE1]
    else $error("enable read back wrong");

  property p_join_pin;
    q.en[1] && q.run[1] && q.ctl[4] && q.pol[1]
      && ({q.cnt[0], q.cnt[1]} < {q.dty[0], q.dty[1]}) |=> PWM_O[1];
  endproperty
  a_join_pin: assert property (p_join_pin) // [RULE16]
    else $error("joined pair pin not driven from the 16-bit count");

  property p_cnt_hold;
    !en_eff[1] |=> q.cnt[1] == $past(q.cnt[1]);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) // [RULE17]
    else $error("disabled channel 1 counter moved");

  property p_off_run;
    !en_eff[1] |=> !q.run[1];
  endproperty
  a_off_run: assert property (p_off_run) // [RULE17] [RULE2]
    else $error("disabled channel 1 still running");

  property p_sel_b;
    q.ab[1] && !q.scl[1] |-> src_tick[1] == ck.tick_b;
  endproperty
  a_sel_b: assert property (p_sel_b) // [RULE13] [RULE12]
    else $error("channel 1 not on clock B");

  property p_sel_sa;
    q.ab[2] && q.scl[2] |-> src_tick[2] == ck.tick_sa;
  endproperty
  a_sel_sa: assert property (p_sel_sa) // [RULE14] [RULE12]
    else $error("channel 2 not on clock SA");

  property p_rd_idle;
    !RD_I |=> RDATA_O == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) // [RULE7]
    else $error("read data not cleared after its cycle");
endmodule // pwmc_top

// [dv/pwmc_top_tb_top.sv]
/*
  pwmc_top_tb_top: self-checking bench for the pwm enable, polarity
  and clock select block, driving its register port and watching pins.
  Assumes the package constants and one 10 MHz bus clock.
*/
module pwmc_top_tb_top
  import pwmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PRESENT = 8'h7F;
  localparam logic [5:0] REGS [4] = '{ADDR_EN, ADDR_POL, ADDR_SCL, ADDR_AB};
  localparam int CH1_TICK [4] = '{1, 4, 2, 8};
  localparam int CH2_TICK [4] = '{2, 8, 1, 4};
  logic ref_clk = 1'b0;
  logic rstn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic wr;
  logic rd;
  logic [NCH-1:0] pwm;
  int n_mismatch = 0;
  int n_compared = 0;
  int h;
  int r;

  pwmc_top #(.CHAN_MASK(PRESENT)) DUT (
    .REF_CLK_I(ref_clk),
    .RSTN_I(rstn),
    .ADDR_I(addr),
    .WDATA_I(wdata),
    .WR_I(wr),
    .RD_I(rd),
    .RDATA_O(rdata),
    .PWM_O(pwm)
  );

  always #50 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    n_compared++;
    if (got != exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk_reg(rdata, e, "read data");
  endtask

  // counts high samples and rising edges of one pin over n cycles
  task automatic watch(input int ch, input int n, output int highs,
                       output int rises);
    logic prev;
    highs = 0;
    rises = 0;
    @(negedge ref_clk);
    prev = pwm[ch];
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      if (pwm[ch] === 1'b1) highs++;
      if (pwm[ch] === 1'b1 && prev === 1'b0) rises++;
      prev = pwm[ch];
    end
  endtask

  initial begin
    rstn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk(ADDR_EN, RST_BYTE);
    rd_chk(ADDR_POL, RST_BYTE);
    rd_chk(ADDR_SCL, RST_BYTE);
    for (int i = 0; i < 4; i++) begin
      wr_reg(REGS[i], 8'hA5);
      rd_chk(REGS[i], 8'hA5 & PRESENT);
      wr_reg(REGS[i], 8'hFF);
      rd_chk(REGS[i], PRESENT);
      wr_reg(REGS[i], 8'h00);
    end
    wr_reg(6'h07, 8'hFF);
    rd_chk(6'h07, 8'h00);
    wr_reg(ADDR_CTL, 8'hFF);
    rd_chk(ADDR_CTL, 8'h70);
    wr_reg(ADDR_CTL, 8'h00);
    // polarity on channel 1, period 4, duty 1, clock A undivided
    wr_reg(ADDR_PER + 6'h01, 8'h04);
    wr_reg(ADDR_DTY + 6'h01, 8'h01);
    wr_reg(ADDR_POL, 8'h02);
    wr_reg(ADDR_EN, 8'h02);
    repeat (2) @(negedge ref_clk);
    chk_reg(pwm, 8'h00, "waveform before tick");
    @(negedge ref_clk);
    chk_reg(pwm, 8'h02, "first pulse after tick");
    repeat (10) @(posedge ref_clk);
    watch(1, 16, h, r);
    chk_cnt(h, 4, "polarity one");
    wr_reg(ADDR_POL, 8'h00);
    repeat (8) @(posedge ref_clk);
    watch(1, 16, h, r);
    chk_cnt(h, 12, "polarity zero");
    wr_reg(ADDR_EN, 8'h00);
    repeat (4) @(posedge ref_clk);
    watch(1, 16, h, r);
    chk_cnt(h, 0, "disabled pin");
    // joined pair 0/1: period 256, duty 64
    wr_reg(ADDR_PER, 8'h01);
    wr_reg(ADDR_PER + 6'h01, 8'h00);
    wr_reg(ADDR_DTY, 8'h00);
    wr_reg(ADDR_DTY + 6'h01, 8'h40);
    wr_reg(ADDR_POL, 8'h02);
    wr_reg(ADDR_CTL, 8'h10);
    wr_reg(ADDR_EN, 8'h01);
    repeat (20) @(posedge ref_clk);
    watch(0, 64, h, r);
    chk_cnt(h, 0, "high channel pin");
    watch(1, 64, h, r);
    chk_cnt(h, 0, "pair off");
    wr_reg(ADDR_EN, 8'h03);
    repeat (300) @(posedge ref_clk);
    watch(1, 256, h, r);
    chk_cnt(h, 64, "joined waveform");
    watch(0, 32, h, r);
    chk_cnt(h, 0, "high channel pin");
    wr_reg(ADDR_EN, 8'h00);
    wr_reg(ADDR_CTL, 8'h00);
    // clock sources: A 1, B 2, SA 4, SB 8 cycles a tick
    wr_reg(ADDR_PRE, 8'h10);
    wr_reg(ADDR_SCLA, 8'h02);
    wr_reg(ADDR_SCLB, 8'h02);
    wr_reg(ADDR_PER + 6'h01, 8'h02);
    wr_reg(ADDR_DTY + 6'h01, 8'h01);
    wr_reg(ADDR_PER + 6'h02, 8'h02);
    wr_reg(ADDR_DTY + 6'h02, 8'h01);
    wr_reg(ADDR_POL, 8'h06);
    for (int k = 0; k < 4; k++) begin
      wr_reg(ADDR_EN, 8'h00);
      wr_reg(ADDR_AB, k[1] ? 8'h06 : 8'h00);
      wr_reg(ADDR_SCL, k[0] ? 8'h06 : 8'h00);
      wr_reg(ADDR_EN, 8'h06);
      repeat (80) @(posedge ref_clk);
      watch(1, 64, h, r);
      chk_cnt(r, 32 / CH1_TICK[k], "clock ch1");
      watch(2, 64, h, r);
      chk_cnt(r, 32 / CH2_TICK[k], "clock ch2");
    end
    // select changed while running: ch1 falls back to clock A
    wr_reg(ADDR_AB, 8'h00);
    wr_reg(ADDR_SCL, 8'h00);
    repeat (40) @(posedge ref_clk);
    watch(1, 64, h, r);
    chk_cnt(r, 32, "select on the fly");
    report_and_stop();
  end

  initial begin
    #2000000;
    n_mismatch++;
    $display("BAD %0t run did not finish", $time);
    report_and_stop();
  end
endmodule // pwmc_top_tb_top
